// ### io_line_pkg.sv
package io_line_pkg;
	localparam int unsigned NUM_LINES = 32;
	localparam logic [11:0] CTRL_ENABLE_OFF        = 12'h000;
	localparam logic [11:0] CTRL_DISABLE_OFF       = 12'h004;
	localparam logic [11:0] OWNERSHIP_STATUS_OFF   = 12'h008;
	localparam logic [11:0] OUTPUT_ENABLE_OFF      = 12'h010;
	localparam logic [11:0] OUTPUT_DISABLE_OFF     = 12'h014;
	localparam logic [11:0] OUTPUT_STATUS_OFF      = 12'h018;
	localparam logic [11:0] SET_OUTPUT_OFF         = 12'h030;
	localparam logic [11:0] CLEAR_OUTPUT_OFF       = 12'h034;
	localparam logic [11:0] OUTPUT_DATA_STATUS_OFF = 12'h038;
	localparam logic [11:0] PIN_LEVEL_STATUS_OFF   = 12'h03C;
	localparam logic [11:0] IRQ_ENABLE_OFF         = 12'h040;
	localparam logic [11:0] IRQ_DISABLE_OFF        = 12'h044;
	localparam logic [11:0] IRQ_MASK_OFF           = 12'h048;
	localparam logic [11:0] IRQ_STATUS_OFF         = 12'h04C;
	localparam logic [11:0] MULTIDRIVE_ENABLE_OFF  = 12'h050;
	localparam logic [11:0] MULTIDRIVE_DISABLE_OFF = 12'h054;
	localparam logic [11:0] MULTIDRIVE_STATUS_OFF  = 12'h058;
	localparam logic [11:0] PULLUP_DISABLE_OFF     = 12'h060;
	localparam logic [11:0] PULLUP_ENABLE_OFF      = 12'h064;
	localparam logic [11:0] PULLUP_STATUS_OFF      = 12'h068;
	localparam logic [11:0] PERIPH_A_SELECT_OFF    = 12'h070;
	localparam logic [11:0] PERIPH_B_SELECT_OFF    = 12'h074;
	localparam logic [11:0] PERIPH_SELECTOR_OFF    = 12'h078;
	localparam logic [11:0] OUTPUT_WRITE_EN_OFF    = 12'h0A0;
	localparam logic [11:0] OUTPUT_WRITE_DIS_OFF   = 12'h0A4;
	localparam logic [11:0] OUTPUT_WRITE_MASK_OFF  = 12'h0A8;
	localparam logic [31:0] ZERO_RESET             = 32'h00000000;
	localparam logic [31:0] IMPLEMENTED_DEFAULT    = 32'hFFFFFFFF;
	localparam logic [31:0] MUXED_DEFAULT          = 32'hFFFFFFFF;
	localparam logic [31:0] OWNERSHIP_DEFAULT      = 32'hFFFFFFFF;

	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
	} periph_drive_t;

	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
		logic [31:0] pullup_en;
	} pad_ctrl_t;
endpackage

// ### io_line_controller.sv
//  Function
// - Pull-up enable clears status, disable sets
// - Reset enables all pull-ups
// - Controller enable/disable sets/clears ownership
// - Unmuxed lines ignore ownership writes, read one
// - Ownership reset value is per-line parameter
// - A select clears, B select sets selector
// - Selector steers outputs only; inputs see pin
// - Selector resets to peripheral A
// - Peripheral owns drive when ownership zero
// - Output enable/disable sets/clears output status
// - Set/clear output write output data
// - Output writes update even when peripheral-owned
// - Direct data write changes masked bits only
// - Write enable/disable sets/clears write mask
// - Write mask resets to zero
// - Multi-drive bit makes line open drain
// - Multi-drive resets to zero
// - Pin level register returns sampled pins
// - Sampling only while gated clock enabled
// - Configuration writes work without gated clock
// - Interrupt only while gated clock enabled
// - Change sets status; masked OR; read clears
// - Unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
module io_line_controller
	import io_line_pkg::*;
#(
	parameter logic [31:0] IMPLEMENTED   = IMPLEMENTED_DEFAULT,
	parameter logic [31:0] MUXED         = MUXED_DEFAULT,
	parameter logic [31:0] OWNERSHIP_RST = OWNERSHIP_DEFAULT
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          clk_enable,
	input  wire logic [31:0]   pad_in,
	output pad_ctrl_t          pad,
	input  periph_drive_t      periph_a,
	input  periph_drive_t      periph_b,
	output logic      [31:0]   periph_in,
	output logic               irq
);
	localparam logic [31:0] OWN_FIXED = IMPLEMENTED & ~MUXED;

	logic [31:0] pullup_status;
	logic [31:0] ownership;
	logic [31:0] selector;
	logic [31:0] output_status;
	logic [31:0] output_data;
	logic [31:0] write_mask;
	logic [31:0] multidrive;
	logic [31:0] irq_mask;
	logic [31:0] irq_status;
	logic [31:0] pin_sync1;
	logic [31:0] pin_sync2;
	logic [31:0] pin_level;
	logic        clk_en_s1;
	logic        clk_en_s2;
	logic        clk_en_d;
	logic [31:0] next_drive_out;
	logic [31:0] next_drive_oe;
	logic [31:0] next_prdata;
	logic [31:0] wdata;
	logic [31:0] change;
	logic        access;
	logic        wr;
	logic        rd;
	logic        mapped;

	default clocking dflt_cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	function automatic logic hit(input logic [11:0] off);
		return wr && (paddr == off);
	endfunction

	assign access = psel && penable && pready;
	assign wr     = access && pwrite;
	assign rd     = access && !pwrite;
	assign wdata  = pwdata & IMPLEMENTED;

	// One wait state: pready is registered high in the second access cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pullup_status <= ZERO_RESET;
		end else if (hit(PULLUP_ENABLE_OFF)) begin
			pullup_status <= pullup_status & ~wdata;
		end else if (hit(PULLUP_DISABLE_OFF)) begin
			pullup_status <= pullup_status | wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ownership <= (OWNERSHIP_RST | OWN_FIXED) & IMPLEMENTED;
		end else if (hit(CTRL_ENABLE_OFF)) begin
			ownership <= ownership | wdata;
		end else if (hit(CTRL_DISABLE_OFF)) begin
			ownership <= (ownership & ~wdata) | OWN_FIXED;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			selector <= ZERO_RESET;
		end else if (hit(PERIPH_A_SELECT_OFF)) begin
			selector <= selector & ~wdata;
		end else if (hit(PERIPH_B_SELECT_OFF)) begin
			selector <= selector | wdata;
		end
	end

	// Writes land regardless of ownership or gated clock
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			output_status <= ZERO_RESET;
		end else if (hit(OUTPUT_ENABLE_OFF)) begin
			output_status <= output_status | wdata;
		end else if (hit(OUTPUT_DISABLE_OFF)) begin
			output_status <= output_status & ~wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			output_data <= ZERO_RESET;
		end else if (hit(SET_OUTPUT_OFF)) begin
			output_data <= output_data | wdata;
		end else if (hit(CLEAR_OUTPUT_OFF)) begin
			output_data <= output_data & ~wdata;
		end else if (hit(OUTPUT_DATA_STATUS_OFF)) begin
			output_data <= (output_data & ~write_mask)
				| (wdata & write_mask);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			write_mask <= ZERO_RESET;
		end else if (hit(OUTPUT_WRITE_EN_OFF)) begin
			write_mask <= write_mask | wdata;
		end else if (hit(OUTPUT_WRITE_DIS_OFF)) begin
			write_mask <= write_mask & ~wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			multidrive <= ZERO_RESET;
		end else if (hit(MULTIDRIVE_ENABLE_OFF)) begin
			multidrive <= multidrive | wdata;
		end else if (hit(MULTIDRIVE_DISABLE_OFF)) begin
			multidrive <= multidrive & ~wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_mask <= ZERO_RESET;
		end else if (hit(IRQ_ENABLE_OFF)) begin
			irq_mask <= irq_mask | wdata;
		end else if (hit(IRQ_DISABLE_OFF)) begin
			irq_mask <= irq_mask & ~wdata;
		end
	end

	// Pin and clock-enable synchronisers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_sync1 <= ZERO_RESET;
			pin_sync2 <= ZERO_RESET;
			clk_en_s1 <= 1'b0;
			clk_en_s2 <= 1'b0;
		end else begin
			pin_sync1 <= pad_in;
			pin_sync2 <= pin_sync1;
			clk_en_s1 <= clk_enable;
			clk_en_s2 <= clk_en_s1;
		end
	end

	// Sampling frozen while gated clock is off
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_level <= ZERO_RESET;
			clk_en_d  <= 1'b0;
		end else begin
			clk_en_d <= clk_en_s2;
			if (clk_en_s2) begin
				pin_level <= pin_sync2 & IMPLEMENTED;
			end
		end
	end

	// Compare only two successive gated samples
	assign change = (clk_en_s2 && clk_en_d) ?
		((pin_sync2 ^ pin_level) & IMPLEMENTED) : ZERO_RESET;

	// New change wins over the read clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_status <= ZERO_RESET;
		end else if (rd && paddr == IRQ_STATUS_OFF) begin
			irq_status <= change;
		end else begin
			irq_status <= irq_status | change;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= clk_en_s2 && |(irq_status & irq_mask);
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_LINES; i++) begin
			if (ownership[i]) begin
				next_drive_out[i] = output_data[i];
				next_drive_oe[i]  = output_status[i];
			end else if (selector[i]) begin
				next_drive_out[i] = periph_b.out[i];
				next_drive_oe[i]  = periph_b.oe[i];
			end else begin
				next_drive_out[i] = periph_a.out[i];
				next_drive_oe[i]  = periph_a.oe[i];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pad.out       <= ZERO_RESET;
			pad.oe        <= ZERO_RESET;
			pad.pullup_en <= IMPLEMENTED;
			periph_in <= ZERO_RESET;
		end else begin
			pad.out <= next_drive_out & IMPLEMENTED;
			// Open drain: drive only the low level
			pad.oe <= next_drive_oe & ~(multidrive & next_drive_out)
				& IMPLEMENTED;
			pad.pullup_en <= ~pullup_status & IMPLEMENTED;
			periph_in     <= pin_sync2;
		end
	end

	always_comb begin
		mapped      = 1'b1;
		next_prdata = ZERO_RESET;
		unique case (paddr)
			OWNERSHIP_STATUS_OFF:   next_prdata = ownership;
			OUTPUT_STATUS_OFF:      next_prdata = output_status;
			OUTPUT_DATA_STATUS_OFF: next_prdata = output_data;
			PIN_LEVEL_STATUS_OFF:   next_prdata = pin_level;
			IRQ_MASK_OFF:           next_prdata = irq_mask;
			IRQ_STATUS_OFF:         next_prdata = irq_status;
			MULTIDRIVE_STATUS_OFF:  next_prdata = multidrive;
			PULLUP_STATUS_OFF:      next_prdata = pullup_status;
			PERIPH_SELECTOR_OFF:    next_prdata = selector;
			OUTPUT_WRITE_MASK_OFF:  next_prdata = write_mask;
			CTRL_ENABLE_OFF, CTRL_DISABLE_OFF, OUTPUT_ENABLE_OFF,
			OUTPUT_DISABLE_OFF, SET_OUTPUT_OFF, CLEAR_OUTPUT_OFF,
			IRQ_ENABLE_OFF, IRQ_DISABLE_OFF, MULTIDRIVE_ENABLE_OFF,
			MULTIDRIVE_DISABLE_OFF, PULLUP_DISABLE_OFF,
			PULLUP_ENABLE_OFF, PERIPH_A_SELECT_OFF,
			PERIPH_B_SELECT_OFF, OUTPUT_WRITE_EN_OFF,
			OUTPUT_WRITE_DIS_OFF:   next_prdata = ZERO_RESET;
			default:                mapped = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata  <= ZERO_RESET;
			pslverr <= 1'b0;
		end else begin
			prdata  <= (psel && !pwrite) ?
				(next_prdata & IMPLEMENTED) : ZERO_RESET;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	a_pullup_enable: assert property (hit(PULLUP_ENABLE_OFF) |=>
		(pullup_status & $past(wdata)) == 0)
		else $error("pull-up enable did not clear status");
	a_pullup_disable: assert property (hit(PULLUP_DISABLE_OFF) |=>
		(pullup_status & $past(wdata)) == $past(wdata))
		else $error("pull-up disable did not set status");
	a_pullup_pad: assert property (
		pad.pullup_en == (~$past(pullup_status) & IMPLEMENTED))
		else $error("pull-up pad control differs from status");
	a_fixed_owner: assert property (
		(ownership & OWN_FIXED) == OWN_FIXED)
		else $error("unmuxed line lost controller ownership");
	a_ctrl_enable: assert property (hit(CTRL_ENABLE_OFF) |=>
		(ownership & $past(wdata)) == $past(wdata))
		else $error("controller enable did not set ownership");
	a_ctrl_disable: assert property (hit(CTRL_DISABLE_OFF) |=>
		(ownership & $past(wdata) & ~OWN_FIXED) == 0)
		else $error("controller disable did not clear ownership");
	a_selector_a: assert property (hit(PERIPH_A_SELECT_OFF) |=>
		(selector & $past(wdata)) == 0)
		else $error("A select did not clear selector");
	a_selector_b: assert property (hit(PERIPH_B_SELECT_OFF) |=>
		(selector & $past(wdata)) == $past(wdata))
		else $error("B select did not set selector");
	a_periph_drive: assert property (
		(!ownership[16] && !selector[16] && !multidrive[16]) |=>
		pad.oe[16] == $past(periph_a.oe[16]) &&
		pad.out[16] == $past(periph_a.out[16]))
		else $error("peripheral A does not drive line 16");
	a_ctrl_drive: assert property (
		(ownership[4] && !multidrive[4]) |=>
		pad.oe[4] == $past(output_status[4]) &&
		pad.out[4] == $past(output_data[4]))
		else $error("controller settings do not drive line 4");
	a_output_enable: assert property (hit(OUTPUT_ENABLE_OFF) |=>
		(output_status & $past(wdata)) == $past(wdata))
		else $error("output enable did not set status");
	a_output_clear: assert property (hit(CLEAR_OUTPUT_OFF) |=>
		(output_data & $past(wdata)) == 0)
		else $error("clear output did not clear data");
	a_masked_write: assert property (
		hit(OUTPUT_DATA_STATUS_OFF) |=> ((output_data ^
		$past(output_data)) & ~$past(write_mask)) == 0)
		else $error("unmasked output data bit changed");
	a_mask_enable: assert property (hit(OUTPUT_WRITE_EN_OFF) |=>
		(write_mask & $past(wdata)) == $past(wdata))
		else $error("write enable did not set mask");
	a_multidrive_set: assert property (
		hit(MULTIDRIVE_ENABLE_OFF) |=>
		(multidrive & $past(wdata)) == $past(wdata))
		else $error("multi-drive enable did not set status");
	a_open_drain: assert property (
		(multidrive[3] && next_drive_out[3]) |=> !pad.oe[3])
		else $error("open drain line driven high");
	a_level_hold: assert property (
		!clk_en_s2 |=> $stable(pin_level))
		else $error("pin level changed with clock off");
	a_irq_gate: assert property (!clk_en_s2 |=> !irq)
		else $error("interrupt asserted with clock off");
	a_irq_enable: assert property (hit(IRQ_ENABLE_OFF) |=>
		(irq_mask & $past(wdata)) == $past(wdata))
		else $error("interrupt enable did not set mask");
	a_irq_clear: assert property (
		(rd && paddr == IRQ_STATUS_OFF && change == 0) |=>
		irq_status == 0)
		else $error("status read did not clear interrupts");
	a_unimpl_zero: assert property ((prdata & ~IMPLEMENTED) == 0)
		else $error("unimplemented bit read nonzero");

	c_periph_b: cover property (@(posedge mclk) disable iff (rst)
		!ownership[0] && selector[0] && pad.oe[0]);
	c_irq: cover property (@(posedge mclk) disable iff (rst) irq);
	c_masked: cover property (@(posedge mclk) disable iff (rst)
		hit(OUTPUT_DATA_STATUS_OFF) && write_mask != 0);
	c_err: cover property (@(posedge mclk) disable iff (rst) pslverr);
endmodule

// ### pin_model.sv
`timescale 1ns/1ps
module pin_model
	import io_line_pkg::*;
(
	input  wire logic [31:0] ext_oe,
	input  wire logic [31:0] ext_val,
	input  wire logic        mclk,
	input  pad_ctrl_t        pad,
	output logic      [31:0] pad_in,
	output periph_drive_t    periph_a,
	output periph_drive_t    periph_b
);
	logic [31:0] drift = 32'h0;
	logic [31:0] low;
	logic [31:0] high;
	// Undriven lines with no pull-up wander every cycle
	always @(posedge mclk)
		drift <= ~drift;
	// Any low driver wins, then a high driver, then the pull-up
	assign low      = (pad.oe & ~pad.out) | (ext_oe & ~ext_val);
	assign high     = (pad.oe & pad.out) | (ext_oe & ext_val) | pad.pullup_en;
	assign pad_in   = ~low & (high | drift);
	assign periph_a = '{out: 32'hA5A5A5A5, oe: 32'h0FF00FF0};
	assign periph_b = '{out: 32'h3C3C3C3C, oe: 32'h5AA55AA5};
endmodule

// ### tb_io_line_controller.sv
`timescale 1ns/1ps
module tb_io_line_controller import io_line_pkg::*;;
	logic          mclk, rst, psel, penable, pwrite, pready, pslverr, re;
	logic          clk_enable, irq;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, pad_in, periph_in, ext_oe, ext_val, rq;
	pad_ctrl_t     pad;
	periph_drive_t periph_a, periph_b;
	int            failures, tests_run;

	io_line_controller #(.MUXED(32'hFFFFFFFE), .OWNERSHIP_RST(32'h7FFFFFFF))
	i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clk_enable(clk_enable),
		.pad_in(pad_in), .pad(pad), .periph_a(periph_a),
		.periph_b(periph_b), .periph_in(periph_in), .irq(irq));
	pin_model i_pins (.ext_oe(ext_oe), .ext_val(ext_val), .mclk(mclk),
		.pad(pad), .pad_in(pad_in), .periph_a(periph_a),
		.periph_b(periph_b));

	task automatic conclude();
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'h1);
		rq = prdata;
		re = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		check($sformatf("reg %h", a), rq, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic reset_values();
		rd(PULLUP_STATUS_OFF, 32'h00000000);
		rd(OWNERSHIP_STATUS_OFF, 32'h7FFFFFFF);
		rd(PERIPH_SELECTOR_OFF, 32'h00000000);
		rd(OUTPUT_WRITE_MASK_OFF, 32'h00000000);
		rd(MULTIDRIVE_STATUS_OFF, 32'h00000000);
		check("pullup_en", pad.pullup_en, 32'hFFFFFFFF);
		apb(1'h0, 12'h0FC, 32'h0);
		check("unmapped", {rq[30:0], re}, 32'h00000001);
	endtask
	task automatic set_clear();
		logic [11:0] t [7][3];
		t = '{'{CTRL_ENABLE_OFF, CTRL_DISABLE_OFF, OWNERSHIP_STATUS_OFF},
			'{PULLUP_DISABLE_OFF, PULLUP_ENABLE_OFF, PULLUP_STATUS_OFF},
			'{PERIPH_B_SELECT_OFF, PERIPH_A_SELECT_OFF, PERIPH_SELECTOR_OFF},
			'{OUTPUT_ENABLE_OFF, OUTPUT_DISABLE_OFF, OUTPUT_STATUS_OFF},
			'{SET_OUTPUT_OFF, CLEAR_OUTPUT_OFF, OUTPUT_DATA_STATUS_OFF},
			'{OUTPUT_WRITE_EN_OFF, OUTPUT_WRITE_DIS_OFF, OUTPUT_WRITE_MASK_OFF},
			'{MULTIDRIVE_ENABLE_OFF, MULTIDRIVE_DISABLE_OFF,
				MULTIDRIVE_STATUS_OFF}};
		for (int i = 0; i < 7; i++) begin
			wr(t[i][1], 32'hFFFFFFFF);
			wr(t[i][0], 32'h0F0FF0F0);
			wr(t[i][1], 32'h000000FF);
			rd(t[i][2], 32'h0F0FF000 | {31'h0, i == 0});
		end
		tick(2);
		check("pullup_en", pad.pullup_en, 32'hF0F00FFF);
	endtask
	task automatic direct_write();
		wr(OUTPUT_WRITE_DIS_OFF, 32'hFFFFFFFF);
		wr(OUTPUT_DATA_STATUS_OFF, 32'hFFFFFFFF);
		rd(OUTPUT_DATA_STATUS_OFF, 32'h0F0FF000);
		wr(OUTPUT_WRITE_EN_OFF, 32'h000000FF);
		wr(OUTPUT_DATA_STATUS_OFF, 32'hAAAAAA5A);
		rd(OUTPUT_DATA_STATUS_OFF, 32'h0F0FF05A);
	endtask
	task automatic periph_own();
		logic [31:0] eo;
		logic [31:0] ee;
		wr(PULLUP_ENABLE_OFF, 32'hFFFFFFFF);
		wr(MULTIDRIVE_DISABLE_OFF, 32'hFFFFFFFF);
		wr(CTRL_ENABLE_OFF, 32'hFFFFFFFF);
		wr(OUTPUT_ENABLE_OFF, 32'hFFFFFFFF);
		wr(CLEAR_OUTPUT_OFF, 32'hFFFFFFFF);
		wr(SET_OUTPUT_OFF, 32'h12345678);
		wr(PERIPH_A_SELECT_OFF, 32'hFFFFFFFF);
		wr(PERIPH_B_SELECT_OFF, 32'hFF000000);
		wr(CTRL_DISABLE_OFF, 32'hFFFF0000);
		eo = {periph_b.out[31:24], periph_a.out[23:16], 16'h5678};
		ee = {periph_b.oe[31:24], periph_a.oe[23:16], 16'hFFFF};
		tick(4);
		check("pad.out", pad.out, eo);
		check("pad.oe", pad.oe, ee);
		check("periph_in", periph_in, eo | ~ee);
		wr(CLEAR_OUTPUT_OFF, 32'hFFFF0000);
		wr(OUTPUT_DISABLE_OFF, 32'h0F000000);
		tick(2);
		check("pad.out", pad.out, eo);
		wr(CTRL_ENABLE_OFF, 32'hFFFF0000);
		tick(2);
		check("pad.out", pad.out, 32'h00005678);
		check("pad.oe", pad.oe, 32'hF0FFFFFF);
		wr(MULTIDRIVE_ENABLE_OFF, 32'h00000009);
		tick(2);
		check("pad.oe", pad.oe & 32'h00000009, 32'h00000001);
	endtask
	task automatic pin_sample();
		wr(OUTPUT_DISABLE_OFF, 32'hFFFFFFFF);
		ext_val <= 32'hCAFE1234;
		ext_oe <= 32'hFFFFFFFF;
		clk_enable <= 1'h1;
		wr(IRQ_ENABLE_OFF, 32'h00000010);
		tick(8);
		apb(1'h0, IRQ_STATUS_OFF, 32'h0);
		rd(PIN_LEVEL_STATUS_OFF, 32'hCAFE1234);
		ext_val <= 32'hCAFE1224;
		tick(8);
		check("irq", {31'h0, irq}, 32'h00000001);
		rd(IRQ_STATUS_OFF, 32'h00000010);
		tick(3);
		check("irq", {31'h0, irq}, 32'h00000000);
		rd(IRQ_MASK_OFF, 32'h00000010);
		wr(IRQ_DISABLE_OFF, 32'h00000010);
		rd(IRQ_MASK_OFF, 32'h00000000);
		clk_enable <= 1'h0;
		tick(4);
		ext_val <= 32'h0000FFFF;
		tick(8);
		check("irq", {31'h0, irq}, 32'h00000000);
		rd(PIN_LEVEL_STATUS_OFF, 32'hCAFE1224);
	endtask

	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		conclude();
	end
	initial begin
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		clk_enable = 1'h0;
		ext_oe = 32'h0;
		ext_val = 32'h0;
		failures = 0;
		tests_run = 0;
		tick(4);
		check("pullup_en", pad.pullup_en, 32'hFFFFFFFF);
		rst <= 1'h0;
		tick(2);
		reset_values();
		set_clear();
		direct_write();
		periph_own();
		pin_sample();
		conclude();
	end
endmodule
